// ### src/wdt_sup_cfg.svh
// Timing constants of the windowed watchdog supervisor.
// Assumes a 200 MHz system clock and a 100 us internal timebase.
`ifndef WDT_SUP_CFG_SVH
`define WDT_SUP_CFG_SVH

`define CLK_PERIOD_NS     5
`define TICK_NS           100000
`define TICK_CYCLES       (`TICK_NS / `CLK_PERIOD_NS)
`define GLITCH_NS         100
`define FILTER_CYCLES     ((`GLITCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define KICK_MIN_NS       300
`define RESET_HOLD_US     180000
`define RESET_HOLD_TICKS  (`RESET_HOLD_US * 1000 / `TICK_NS)
`define FAULT_PULSE_US    1000
`define FAULT_PULSE_TICKS (`FAULT_PULSE_US * 1000 / `TICK_NS)
`define TICK_CNT_W        20

// Fast window upper limits, in 100 us ticks
`define FAST_A 20'h0000f
`define FAST_B 20'h00096
`define FAST_F 20'h000e6
`define FAST_G 20'h00186
`define FAST_H 20'h01c16
// Slow timeout lower limits, in 100 us ticks
`define SLOW_A 20'h00064
`define SLOW_B 20'h003e8
`define SLOW_C 20'h00bb8
`define SLOW_D 20'h186a0
`define SLOW_E 20'h927c0
`define SLOW_F 20'h001d6
`define SLOW_G 20'h00334
`define SLOW_H 20'h032c8

`endif

// ### src/wdt_sup_pkg.sv
// Types shared by the watchdog supervisor modules.
// Assumes the timing header is compiled alongside.
`default_nettype none
package wdt_sup_pkg;
   typedef enum logic [1:0] {WD_IDLE, WD_RUN, WD_FAULT} wd_state_t;
   typedef logic [2:0] timing_option_t;
endpackage : wdt_sup_pkg
`default_nettype wire

// ### src/glitch_filter.sv
// Glitch filter: output follows input once stable for a number of cycles.
// Assumes a synchronous input.
`default_nettype none
module glitch_filter #(
   parameter int          STABLE_CYCLES = 20,
   parameter logic        RESET_LEVEL   = 1'b1
) (
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic rst_b,
   // Data
   input  wire logic raw_in,
   output logic      clean_out
);
   typedef struct packed {
      logic [15:0] cnt;
      logic        lvl;
   } filt_t;

   filt_t s_q, s_d;

   initial begin
      if (STABLE_CYCLES < 1 || STABLE_CYCLES > 65535) $error("glitch_filter: bad STABLE_CYCLES");
   end

   always_comb begin
      s_d = s_q;
      if (raw_in == s_q.lvl) begin
         s_d.cnt = 16'h0000;
      end else if (s_q.cnt == 16'(STABLE_CYCLES - 1)) begin
         s_d.lvl = raw_in;
         s_d.cnt = 16'h0000;
      end else begin
         s_d.cnt = s_q.cnt + 16'h0001;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         s_q <= '{cnt: 16'h0000, lvl: RESET_LEVEL};
      end else begin
         s_q <= s_d;
      end
   end

   assign clean_out = s_q.lvl;
endmodule : glitch_filter
`default_nettype wire

// ### src/wdt_supervisor.sv
// Processor supervisor: reset generator with hold time and windowed watchdog.
// Assumes all inputs synchronous to clk_sys; option select is a static strap.
`include "wdt_sup_cfg.svh"
`default_nettype none

// How it works
// - Reset output goes low while undervoltage is flagged or manual reset is low.
// - Reset stays low for the hold time after both causes clear.
// - Two kicks closer than the fast limit raise a fault.
// - No kick within the slow timeout raises a fault.
// - Windows run from the latest kick falling edge; kicks held 300 ns.
// - Any fault drives the fault output low for one 1 ms pulse.
// - Eight options select among five fast window limits; options 1 to 4 all use B.
// - Eight options select the slow timeout limit.
// - Manual reset input is filtered against short glitches.
// - First kick after reset release or fault pulse never counts as fast.
// - A kick other than the first before the fast limit expires pulses the fault output.
module wdt_supervisor
   import wdt_sup_pkg::*;
#(
   parameter int TICK_CYCLES  = `TICK_CYCLES,
   parameter int FILT_CYCLES  = `FILTER_CYCLES,
   parameter int HOLD_TICKS   = `RESET_HOLD_TICKS,
   parameter int PULSE_TICKS  = `FAULT_PULSE_TICKS
) (
   // Clock and reset
   input  wire logic           clk_sys,
   input  wire logic           rst_b,
   // Supply and manual reset
   input  wire logic           undervoltage_in,
   input  wire logic           manual_reset_in_n,
   // Watchdog
   input  wire logic           kick_input,
   input  wire timing_option_t option_sel,
   // Outputs
   output logic                sys_reset_out_n,
   output logic                fault_pulse_out_n
);
   localparam int CW = `TICK_CNT_W;

   typedef struct packed {
      logic [CW-1:0] div_cnt;
      logic          tick;
      logic [CW-1:0] hold_cnt;
      logic          rst_n;
      wd_state_t     wd;
      logic [CW-1:0] win_cnt;
      logic [CW-1:0] pulse_cnt;
      logic          first_kick;
      logic          kick_prev;
      logic          fault_n;
   } sup_t;

   sup_t s_q, s_d;
   logic mr_clean_n;
   logic kick_clean;
   logic kick_fall;

   initial begin
      if (TICK_CYCLES < 2 || TICK_CYCLES >= (1 << CW)) $error("wdt_supervisor: bad TICK_CYCLES");
      if (HOLD_TICKS < 1 || HOLD_TICKS >= (1 << CW)) $error("wdt_supervisor: bad HOLD_TICKS");
      if (PULSE_TICKS < 1 || PULSE_TICKS >= (1 << CW)) $error("wdt_supervisor: bad PULSE_TICKS");
      if (FILT_CYCLES * `CLK_PERIOD_NS > `KICK_MIN_NS) $error("wdt_supervisor: filter eats kick");
   end

   function automatic logic [CW-1:0] fast_limit(input timing_option_t opt);
      case (opt)
         3'h0:    fast_limit = `FAST_A;
         3'h5:    fast_limit = `FAST_F;
         3'h6:    fast_limit = `FAST_G;
         3'h7:    fast_limit = `FAST_H;
         default: fast_limit = `FAST_B;
      endcase
   endfunction : fast_limit

   function automatic logic [CW-1:0] slow_limit(input timing_option_t opt);
      case (opt)
         3'h0:    slow_limit = `SLOW_A;
         3'h1:    slow_limit = `SLOW_B;
         3'h2:    slow_limit = `SLOW_C;
         3'h3:    slow_limit = `SLOW_D;
         3'h4:    slow_limit = `SLOW_E;
         3'h5:    slow_limit = `SLOW_F;
         3'h6:    slow_limit = `SLOW_G;
         default: slow_limit = `SLOW_H;
      endcase
   endfunction : slow_limit

   glitch_filter #(
      .STABLE_CYCLES (FILT_CYCLES),
      .RESET_LEVEL   (1'b1)
   ) u_mr_filter (
      .clk_sys   (clk_sys),
      .rst_b     (rst_b),
      .raw_in    (manual_reset_in_n),
      .clean_out (mr_clean_n)
   );

   glitch_filter #(
      .STABLE_CYCLES (FILT_CYCLES),
      .RESET_LEVEL   (1'b1)
   ) u_kick_filter (
      .clk_sys   (clk_sys),
      .rst_b     (rst_b),
      .raw_in    (kick_input),
      .clean_out (kick_clean)
   );

   assign kick_fall = s_q.kick_prev && !kick_clean;

   always_comb begin
      s_d           = s_q;
      s_d.kick_prev = kick_clean;

      // Timebase enable
      s_d.tick = 1'b0;
      if (s_q.div_cnt == CW'(TICK_CYCLES - 1)) begin
         s_d.div_cnt = '0;
         s_d.tick    = 1'b1;
      end else begin
         s_d.div_cnt = s_q.div_cnt + 1'b1;
      end

      // Reset generator
      if (undervoltage_in || !mr_clean_n) begin
         s_d.rst_n    = 1'b0;
         s_d.hold_cnt = '0;
      end else if (!s_q.rst_n) begin
         if (s_q.hold_cnt == CW'(HOLD_TICKS)) begin
            s_d.rst_n = 1'b1;
         end else if (s_q.tick) begin
            s_d.hold_cnt = s_q.hold_cnt + 1'b1;
         end
      end

      // Windowed watchdog
      case (s_q.wd)
         WD_IDLE: begin
            s_d.fault_n    = 1'b1;
            s_d.win_cnt    = '0;
            s_d.first_kick = 1'b1;
            if (s_q.rst_n) begin
               s_d.wd = WD_RUN;
            end
         end
         WD_RUN: begin
            if (kick_fall) begin
               if (!s_q.first_kick && s_q.win_cnt < fast_limit(option_sel)) begin
                  s_d.wd        = WD_FAULT;
                  s_d.fault_n   = 1'b0;
                  s_d.pulse_cnt = '0;
               end else begin
                  s_d.win_cnt    = '0;
                  s_d.first_kick = 1'b0;
               end
            end else if (s_q.win_cnt >= slow_limit(option_sel)) begin
               s_d.wd        = WD_FAULT;
               s_d.fault_n   = 1'b0;
               s_d.pulse_cnt = '0;
            end else if (s_q.tick) begin
               s_d.win_cnt = s_q.win_cnt + 1'b1;
            end
         end
         WD_FAULT: begin
            if (s_q.pulse_cnt == CW'(PULSE_TICKS)) begin
               s_d.fault_n    = 1'b1;
               s_d.wd         = WD_RUN;
               s_d.win_cnt    = '0;
               s_d.first_kick = 1'b1;
            end else if (s_q.tick) begin
               s_d.pulse_cnt = s_q.pulse_cnt + 1'b1;
            end
         end
         default: begin
            s_d.wd = WD_IDLE;
         end
      endcase

      // Reset asserted parks the watchdog
      if (!s_q.rst_n) begin
         s_d.wd      = WD_IDLE;
         s_d.fault_n = 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         s_q <= '{div_cnt: '0, tick: 1'b0, hold_cnt: '0, rst_n: 1'b0, wd: WD_IDLE,
                  win_cnt: '0, pulse_cnt: '0, first_kick: 1'b1, kick_prev: 1'b1, fault_n: 1'b1};
      end else begin
         s_q <= s_d;
      end
   end

   assign sys_reset_out_n   = s_q.rst_n;
   assign fault_pulse_out_n = s_q.fault_n;
endmodule : wdt_supervisor
`default_nettype wire

// ### testbench/wdt_sup_chk.sv
// Assertion checker for the supervisor ports.
// Assumes option_sel 0..7 selects slow A..H and fast A, B, B, B, B, F, G, H; bound into wdt_supervisor.
`default_nettype none
module wdt_sup_chk
   import wdt_sup_pkg::*;
#(
   parameter int TICK_CYCLES = 20,
   parameter int FILT_CYCLES = 20,
   parameter int HOLD_TICKS  = 5,
   parameter int PULSE_TICKS = 3
) (
   // Clock and reset
   input wire logic           clk_sys,
   input wire logic           rst_b,
   // Inputs
   input wire logic           undervoltage_in,
   input wire logic           manual_reset_in_n,
   input wire logic           kick_input,
   input wire timing_option_t option_sel,
   // Outputs
   input wire logic           sys_reset_out_n,
   input wire logic           fault_pulse_out_n
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int FAST[8] = '{15, 150, 150, 150, 150, 230, 390, 7190};
   localparam int SLOW[8] = '{100, 1000, 3000, 100000, 600000, 470, 820, 13000};
   localparam int TK = TICK_CYCLES;
   int   mr_lo, clr, k_lo, f_lo, since, fast_c, slow_c;
   logic first_q, acc;
   assign fast_c = FAST[option_sel] * TK;
   assign slow_c = SLOW[option_sel] * TK;
   assign acc = (k_lo == FILT_CYCLES);
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         {mr_lo, clr, k_lo, f_lo, since} <= '0;
         first_q <= 1'b1;
      end else begin
         mr_lo <= manual_reset_in_n ? 0 : mr_lo + 1;
         clr <= (undervoltage_in || !manual_reset_in_n) ? 0 : clr + 1;
         k_lo <= kick_input ? 0 : k_lo + 1;
         f_lo <= fault_pulse_out_n ? 0 : f_lo + 1;
         since <= (!sys_reset_out_n || !fault_pulse_out_n || acc) ? 0 : since + 1;
         first_q <= (!sys_reset_out_n || !fault_pulse_out_n) ? 1'b1 : (acc ? 1'b0 : first_q);
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   sequence quiet4_s; fault_pulse_out_n [*4]; endsequence
   uv_reset_a: assert property (undervoltage_in |=> !sys_reset_out_n) else $error("uv");
   mr_reset_a: assert property (mr_lo == FILT_CYCLES |-> ##[0:4] !sys_reset_out_n) else $error("mr");
   mr_glitch_a: assert property ($fell(sys_reset_out_n) |-> $past(undervoltage_in)
      || mr_lo >= FILT_CYCLES - 1) else $error("glitch");
   hold_min_a: assert property ($rose(sys_reset_out_n) |-> clr >= (HOLD_TICKS - 1) * TK)
      else $error("hold short");
   hold_max_a: assert property (clr == (HOLD_TICKS + 1) * TK + FILT_CYCLES + 4 |-> sys_reset_out_n)
      else $error("hold long");
   idle_a: assert property ($fell(fault_pulse_out_n) |-> $past(sys_reset_out_n)) else $error("idle");
   pulse_min_a: assert property ($rose(fault_pulse_out_n) && sys_reset_out_n
      |-> f_lo >= (PULSE_TICKS - 1) * TK) else $error("pulse short");
   pulse_max_a: assert property (f_lo <= (PULSE_TICKS + 1) * TK + 2) else $error("pulse long");
   fast_kick_a: assert property (acc && !first_q && since < fast_c - TK && sys_reset_out_n
      && fault_pulse_out_n |-> ##[1:4] !fault_pulse_out_n) else $error("fast");
   first_kick_a: assert property (acc && first_q && fault_pulse_out_n |=> quiet4_s)
      else $error("first");
   good_kick_a: assert property (acc && since > fast_c + TK && since < slow_c - 2 * TK
      && fault_pulse_out_n |=> quiet4_s) else $error("good kick");
   slow_max_a: assert property (sys_reset_out_n && fault_pulse_out_n
      |-> since <= slow_c + TK + FILT_CYCLES + 4) else $error("slow late");
   slow_min_a: assert property ($fell(fault_pulse_out_n) |-> since <= 6 || since >= slow_c - TK)
      else $error("slow early");
endmodule : wdt_sup_chk
bind wdt_supervisor wdt_sup_chk #(.TICK_CYCLES(TICK_CYCLES), .FILT_CYCLES(FILT_CYCLES),
   .HOLD_TICKS(HOLD_TICKS), .PULSE_TICKS(PULSE_TICKS)) u_chk (.clk_sys(clk_sys), .rst_b(rst_b),
   .undervoltage_in(undervoltage_in), .manual_reset_in_n(manual_reset_in_n), .kick_input(kick_input),
   .option_sel(option_sel), .sys_reset_out_n(sys_reset_out_n), .fault_pulse_out_n(fault_pulse_out_n));
`default_nettype wire

// ### testbench/cpu_model.sv
// Processor model: issues one watchdog kick per request.
// Assumes go is a one-cycle request from the bench.
`default_nettype none
module cpu_model (
   // Clock and request
   input  wire logic clk_sys,
   input  wire logic go,
   // Kick line
   output logic      kick_input
);
   timeunit 1ns;
   timeprecision 1ps;
   int n_q = 0;
   always @(posedge clk_sys) n_q <= go ? 64 : (n_q > 0 ? n_q - 1 : 0); // Low 320 ns
   assign kick_input = (n_q == 0);
endmodule : cpu_model
`default_nettype wire

// ### testbench/testbench.sv
// Self-checking bench for the watchdog supervisor.
// Assumes shortened timebase: 20 cycles a tick, hold 5, pulse 3 ticks.
`default_nettype none
module testbench;
   import wdt_sup_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TK = 20, HT = 5, PT = 3;
   logic clk_sys = 0, rst_b = 0, uv = 0, mr = 1, go = 0, kick, srst, fault;
   timing_option_t opt = '0;
   int fails = 0, total_checks = 0;
   always #2.5 clk_sys = ~clk_sys;
   cpu_model cpu (.clk_sys(clk_sys), .go(go), .kick_input(kick));
   wdt_supervisor #(.TICK_CYCLES(TK), .FILT_CYCLES(20), .HOLD_TICKS(HT), .PULSE_TICKS(PT)) dut (
      .clk_sys(clk_sys), .rst_b(rst_b), .undervoltage_in(uv), .manual_reset_in_n(mr),
      .kick_input(kick), .option_sel(opt), .sys_reset_out_n(srst), .fault_pulse_out_n(fault));
   task automatic cyc(input int n); repeat (n) @(posedge clk_sys); endtask : cyc
   task automatic chk(input logic got, input logic exp, input string m);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask : chk
   task automatic give_verdict;
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : give_verdict
   task automatic do_kick; cyc(1); go <= 1; cyc(1); go <= 0; endtask : do_kick
   task automatic do_reset(input timing_option_t o);
      cyc(1); rst_b <= 0; opt <= o;
      cyc(6); rst_b <= 1;
      cyc(HT * TK - TK - 5); chk(srst, 0, "early release");
      cyc(2 * TK + 30); chk(srst, 1, "no release");
   endtask : do_reset
   task automatic t_fast(input int fl);
      do_kick; cyc(30); chk(fault, 1, "first kick");
      cyc(fl * TK / 2 - 32); do_kick; cyc(30); chk(fault, 0, "no fast fault");
      cyc((PT - 1) * TK - 10); chk(fault, 0, "pulse short");
      cyc(2 * TK + 40); chk(fault, 1, "pulse long");
   endtask : t_fast
   task automatic t_slow(input int fl, input int sl);
      do_kick; cyc(fl * TK + 2 * TK); do_kick; cyc(30); chk(fault, 1, "good kick");
      cyc(sl * TK - 2 * TK - 30); chk(fault, 1, "slow early");
      cyc(3 * TK + 30); chk(fault, 0, "no slow fault");
      cyc((PT + 1) * TK + 10);
   endtask : t_slow
   task automatic t_supply;
      uv <= 1; cyc(2); chk(srst, 0, "uv");
      uv <= 0; cyc(HT * TK - TK - 5); chk(srst, 0, "uv hold");
      cyc(2 * TK + 30); chk(srst, 1, "uv release");
      mr <= 0; cyc(8); mr <= 1; cyc(30); chk(srst, 1, "glitch passed");
      mr <= 0; cyc(30); chk(srst, 0, "mr");
      mr <= 1; cyc((HT + 2) * TK + 60); chk(srst, 1, "mr release");
   endtask : t_supply
   int ol[4] = '{0, 1, 5, 6}, fl[4] = '{15, 150, 230, 390}, sl[4] = '{100, 1000, 470, 820};
   int ox[3] = '{2, 3, 4};
   initial begin
      for (int i = 0; i < 4; i++) begin
         do_reset(ol[i][2:0]);
         t_fast(fl[i]);
         t_slow(fl[i], sl[i]);
      end
      // Options 2 to 4, whose slow limit is too long to run: fast limit only
      for (int i = 0; i < 3; i++) begin
         do_reset(ox[i][2:0]);
         t_fast(150);
      end
      t_supply;
      give_verdict;
   end
   initial begin
      cyc(90000);
      fails++;
      give_verdict;
   end
endmodule : testbench
`default_nettype wire
